// >>> hdl/spc_defs.svh
// Register offsets, field positions, reset values and timing counts of the sleep controller
// Included by the controller and the testbench; definitions only
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_CORE_CTRL_OFS 4'h0
`define SPC_CLK_GATE_OFS 4'h4
`define SPC_STATUS_OFS 4'h8
`define SPC_SE_BIT 5
`define SPC_SM_HI 4
`define SPC_SM_LO 3
`define SPC_CORE_CTRL_MASK 8'hfb
`define SPC_CLK_GATE_MASK 8'h0f
`define SPC_CORE_CTRL_RST 8'h00
`define SPC_CLK_GATE_RST 8'h00
`define SPC_TIM1_BIT 3
`define SPC_TIM0_BIT 2
`define SPC_SER_BIT 1
`define SPC_ADC_BIT 0
`define SPC_WAKE_HALT_CYC 4'h4
`define SPC_STBY_WAKE_CYC 4'h6
`define SPC_STARTUP_CYC 4'h8
`endif

// >>> hdl/spc_pkg.sv
// Types shared by the sleep controller
// Assumes spc_defs.svh is on the include path
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_MODE_IDLE,
        SPC_MODE_ADCNR,
        SPC_MODE_PDOWN,
        SPC_MODE_STBY
    } spc_mode_t;
    typedef enum logic [1:0] {
        SPC_ST_RUN,
        SPC_ST_SLEEP,
        SPC_ST_WAKE
    } spc_state_t;
endpackage

// >>> hdl/spc_sleep_ctrl.sv
// Sleep mode and peripheral clock gate controller with an Avalon-MM register slave
// Assumes the core pulses sleep_instr_i and that all inputs are synchronous to mclk_i
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "spc_defs.svh"
module spc_sleep_ctrl (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sleep_instr_i,
    input wire logic crystal_clk_i,
    input wire logic any_reset_i,
    input wire logic irq_enabled_i,
    input wire logic irq_adc_done_i,
    input wire logic irq_spm_ee_i,
    input wire logic irq_external_interrupt_zero_level_i,
    input wire logic irq_pin_change_i,
    input wire logic irq_wdt_i,
    input wire logic irq_other_io_i,
    input wire logic adc_enabled_i,
    input wire logic wdt_enabled_i,
    input wire logic bod_enabled_i,
    input wire logic acmp_bandgap_i,
    input wire logic [3:0] periph_sel_i,
    output logic cpu_clk_en_o,
    output logic flash_clk_en_o,
    output logic io_clk_en_o,
    output logic adc_clk_en_o,
    output logic osc_en_o,
    output logic timer1_clk_en_o,
    output logic timer0_clk_en_o,
    output logic serial_clk_en_o,
    output logic adcp_clk_en_o,
    output logic periph_access_ok_o,
    output logic adc_start_o,
    output logic acmp_disable_o,
    output logic acmp_mux_block_o,
    output logic input_buf_off_o,
    output logic adc_keep_en_o,
    output logic wdt_keep_en_o,
    output logic bod_keep_en_o,
    output logic cpu_halt_o,
    output logic resume_o,
    output logic irq_service_o,
    output logic reset_vector_o
);
    import spc_pkg::*;

    typedef struct packed {
        logic [7:0] core_ctrl;
        logic [7:0] clk_gate;
        spc_state_t state;
        spc_mode_t mode;
        logic [3:0] cnt;
        logic [31:0] rdata;
        logic ack;
        logic adc_start;
        logic resume;
        logic irq_service;
        logic reset_vector;
        logic [4:0] clk_on;
    } spc_state_s_t;

    spc_state_s_t st_ff;
    spc_state_s_t nxt_st;
    logic wake_src;
    logic [3:0] gate_on;
    logic req;
    spc_mode_t sel_mode;

    assign req = avs_read_i | avs_write_i;
    assign sel_mode = spc_mode_t'(st_ff.core_ctrl[`SPC_SM_HI:`SPC_SM_LO]);

    // Wake sources depend on the mode that was entered
    always_comb begin
        wake_src = 1'b0;
        case (st_ff.mode)
            SPC_MODE_IDLE: wake_src = irq_enabled_i;
            SPC_MODE_ADCNR: wake_src = irq_adc_done_i | irq_spm_ee_i | irq_external_interrupt_zero_level_i
                                       | irq_pin_change_i | irq_wdt_i;
            SPC_MODE_PDOWN: wake_src = irq_external_interrupt_zero_level_i | irq_pin_change_i | irq_wdt_i;
            SPC_MODE_STBY: wake_src = irq_external_interrupt_zero_level_i | irq_pin_change_i | irq_wdt_i;
            default: wake_src = 1'b0;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.adc_start = 1'b0;
        nxt_st.resume = 1'b0;
        nxt_st.irq_service = 1'b0;
        nxt_st.reset_vector = 1'b0;
        // Register slave answers one cycle after the request is seen
        if (req && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            case (avs_address_i)
                `SPC_CORE_CTRL_OFS: begin
                    nxt_st.rdata[7:0] = st_ff.core_ctrl & `SPC_CORE_CTRL_MASK;
                end
                `SPC_CLK_GATE_OFS: begin
                    nxt_st.rdata[7:0] = st_ff.clk_gate & `SPC_CLK_GATE_MASK;
                end
                `SPC_STATUS_OFS: begin
                    nxt_st.rdata[1:0] = st_ff.state;
                    nxt_st.rdata[3:2] = st_ff.mode;
                end
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        // A write lands only at the edge where the master sees waitrequest low
        if (avs_write_i && st_ff.ack) begin
            case (avs_address_i)
                `SPC_CORE_CTRL_OFS: begin
                    nxt_st.core_ctrl = avs_writedata_i[7:0] & `SPC_CORE_CTRL_MASK;
                end
                `SPC_CLK_GATE_OFS: begin
                    nxt_st.clk_gate = avs_writedata_i[7:0] & `SPC_CLK_GATE_MASK;
                end
                default: nxt_st.ack = 1'b0;
            endcase
        end
        case (st_ff.state)
            SPC_ST_RUN: begin
                if (sleep_instr_i && st_ff.core_ctrl[`SPC_SE_BIT]) begin
                    nxt_st.state = SPC_ST_SLEEP;
                    // Standby without a crystal falls back to power-down
                    if (sel_mode == SPC_MODE_STBY && !crystal_clk_i) begin
                        nxt_st.mode = SPC_MODE_PDOWN;
                    end else begin
                        nxt_st.mode = sel_mode;
                    end
                    nxt_st.adc_start = adc_enabled_i
                        && (sel_mode == SPC_MODE_IDLE || sel_mode == SPC_MODE_ADCNR);
                end else if (sleep_instr_i) begin
                    nxt_st.resume = 1'b1;
                end
            end
            SPC_ST_SLEEP: begin
                if (wake_src) begin
                    nxt_st.state = SPC_ST_WAKE;
                    if (st_ff.mode == SPC_MODE_PDOWN) begin
                        nxt_st.cnt = `SPC_STARTUP_CYC + `SPC_WAKE_HALT_CYC;
                    end else if (st_ff.mode == SPC_MODE_STBY) begin
                        nxt_st.cnt = `SPC_STBY_WAKE_CYC;
                    end else begin
                        nxt_st.cnt = `SPC_WAKE_HALT_CYC;
                    end
                end
            end
            SPC_ST_WAKE: begin
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state = SPC_ST_RUN;
                    nxt_st.irq_service = 1'b1;
                    nxt_st.resume = 1'b1;
                end
                nxt_st.cnt = st_ff.cnt - 4'h1;
            end
            default: nxt_st.state = SPC_ST_RUN;
        endcase
        // {cpu, flash, io, adc, osc} enables per state and mode
        nxt_st.clk_on = 5'h1f;
        if (nxt_st.state == SPC_ST_SLEEP) begin
            case (nxt_st.mode)
                SPC_MODE_IDLE: nxt_st.clk_on = 5'h07;
                SPC_MODE_ADCNR: nxt_st.clk_on = 5'h03;
                SPC_MODE_PDOWN: nxt_st.clk_on = 5'h00;
                SPC_MODE_STBY: nxt_st.clk_on = 5'h01;
                default: nxt_st.clk_on = 5'h1f;
            endcase
        end else if (nxt_st.state == SPC_ST_WAKE) begin
            nxt_st.clk_on = 5'h07;
        end
        // Reset wakes unconditionally and reloads core_ctrl and clk_gate with their reset values
        if (any_reset_i) begin
            nxt_st.state = SPC_ST_RUN;
            nxt_st.reset_vector = (st_ff.state != SPC_ST_RUN);
            nxt_st.core_ctrl = `SPC_CORE_CTRL_RST;
            nxt_st.clk_gate = `SPC_CLK_GATE_RST;
            nxt_st.clk_on = 5'h1f;
            nxt_st.resume = 1'b0;
            nxt_st.irq_service = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{core_ctrl: `SPC_CORE_CTRL_RST, clk_gate: `SPC_CLK_GATE_RST,
                       state: SPC_ST_RUN, mode: SPC_MODE_IDLE, cnt: 4'h0,
                       rdata: 32'h0000_0000, clk_on: 5'h1f, default: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Gated clocks hold peripheral state, so clearing a bit resumes it while the io clock runs
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_gate
            assign gate_on[gi] = ~st_ff.clk_gate[gi] & st_ff.clk_on[2];
        end
    endgenerate

    assign avs_waitrequest_o = req & ~st_ff.ack;
    assign avs_readdata_o = st_ff.rdata;
    assign cpu_clk_en_o = st_ff.clk_on[4];
    assign flash_clk_en_o = st_ff.clk_on[3];
    assign io_clk_en_o = st_ff.clk_on[2];
    assign adc_clk_en_o = st_ff.clk_on[1];
    assign osc_en_o = st_ff.clk_on[0];
    assign timer1_clk_en_o = gate_on[`SPC_TIM1_BIT];
    assign timer0_clk_en_o = gate_on[`SPC_TIM0_BIT];
    assign serial_clk_en_o = gate_on[`SPC_SER_BIT];
    assign adcp_clk_en_o = gate_on[`SPC_ADC_BIT];
    assign periph_access_ok_o = ~|(st_ff.clk_gate[3:0] & periph_sel_i);
    assign adc_start_o = st_ff.adc_start;
    assign acmp_mux_block_o = st_ff.clk_gate[`SPC_ADC_BIT];
    assign acmp_disable_o = (st_ff.state == SPC_ST_SLEEP) && !acmp_bandgap_i
        && (st_ff.mode == SPC_MODE_PDOWN || st_ff.mode == SPC_MODE_STBY);
    assign input_buf_off_o = ~st_ff.clk_on[2] & ~st_ff.clk_on[1];
    assign adc_keep_en_o = adc_enabled_i;
    assign wdt_keep_en_o = wdt_enabled_i;
    assign bod_keep_en_o = bod_enabled_i;
    assign cpu_halt_o = ~st_ff.clk_on[4];
    assign resume_o = st_ff.resume;
    assign irq_service_o = st_ff.irq_service;
    assign reset_vector_o = st_ff.reset_vector;

    // Wait longest is power-down, start-up plus halt; a source seen for one cycle starts the wake
    sequence s_sleep_entry;
        sleep_instr_i && st_ff.core_ctrl[`SPC_SE_BIT] && st_ff.state == SPC_ST_RUN && !any_reset_i;
    endsequence
    sequence s_pdown_wake;
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_PDOWN && !any_reset_i
        && (irq_external_interrupt_zero_level_i || irq_pin_change_i || irq_wdt_i);
    endsequence
    sequence s_no_reset8;
        !any_reset_i [*8];
    endsequence
    sequence s_no_reset4;
        !any_reset_i [*4];
    endsequence
    // Power-down wake is start-up plus halt, too long for one repetition
    AST_PDOWN_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_pdown_wake ##1 s_no_reset8 ##1 s_no_reset4 |=> irq_service_o && resume_o)
        else $error("power-down wake timing");
    AST_WAKE_HALT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_WAKE |-> cpu_halt_o) else $error("cpu runs during wake");
    AST_SLEEP_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_sleep_entry |=> st_ff.state == SPC_ST_SLEEP) else $error("sleep not entered");
    AST_STBY_FALLBACK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_sleep_entry ##0 (sel_mode == SPC_MODE_STBY && !crystal_clk_i)
        |=> st_ff.mode == SPC_MODE_PDOWN) else $error("standby without crystal");
    AST_STBY_OSC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_STBY
        |-> osc_en_o && !io_clk_en_o && !cpu_clk_en_o) else $error("standby clocks wrong");
    AST_ADCNR_START: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_sleep_entry ##0 (adc_enabled_i && sel_mode == SPC_MODE_ADCNR)
        |=> adc_start_o) else $error("no adc start in noise reduction");
    AST_NO_ADC_START: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_sleep_entry ##0 (!adc_enabled_i || sel_mode[1])
        |=> !adc_start_o) else $error("spurious adc start");
    AST_ADCNR_NO_IO_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_ADCNR && !any_reset_i
        && !irq_adc_done_i && !irq_spm_ee_i && !irq_external_interrupt_zero_level_i && !irq_pin_change_i
        && !irq_wdt_i |=> st_ff.state == SPC_ST_SLEEP) else $error("bad noise reduction wake");
    AST_ACMP_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode[1] && !acmp_bandgap_i
        |-> acmp_disable_o) else $error("comparator left on");
    AST_ACMP_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        acmp_bandgap_i |-> !acmp_disable_o) else $error("bandgap comparator disabled");
    AST_INBUF_AWAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_RUN |-> !input_buf_off_o) else $error("buffers off while running");
    AST_KEEP_EN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        adc_keep_en_o == adc_enabled_i && wdt_keep_en_o == wdt_enabled_i
        && bod_keep_en_o == bod_enabled_i) else $error("enable dropped in sleep");
    AST_MUX_BLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.clk_gate[`SPC_ADC_BIT] |-> acmp_mux_block_o) else $error("mux not blocked");
    AST_GATE_RESUME: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !st_ff.clk_gate[`SPC_TIM0_BIT] && io_clk_en_o |-> timer0_clk_en_o)
        else $error("timer0 clock not resumed");
    AST_RESET_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        any_reset_i |=> st_ff.core_ctrl == `SPC_CORE_CTRL_RST
        && st_ff.clk_gate == `SPC_CLK_GATE_RST) else $error("reset left registers");
    AST_WAIT_ONE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("waitrequest too long");
    AST_CORE_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        avs_write_i && !avs_waitrequest_o && avs_address_i == `SPC_CORE_CTRL_OFS && !any_reset_i
        |=> st_ff.core_ctrl == ($past(avs_writedata_i[7:0]) & `SPC_CORE_CTRL_MASK))
        else $error("core write lost");
    AST_GATE_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        avs_write_i && !avs_waitrequest_o && avs_address_i == `SPC_CLK_GATE_OFS && !any_reset_i
        |=> st_ff.clk_gate == ($past(avs_writedata_i[7:0]) & `SPC_CLK_GATE_MASK))
        else $error("gate write lost");
    AST_CORE_RSV_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !avs_waitrequest_o && avs_read_i && avs_address_i == `SPC_CORE_CTRL_OFS
        |-> avs_readdata_o[2] == 1'b0 && avs_readdata_o[31:8] == 24'h0)
        else $error("reserved core bit set");
    AST_SLEEP_NEEDS_SE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_RUN && sleep_instr_i && !st_ff.core_ctrl[`SPC_SE_BIT] && !any_reset_i
        |=> st_ff.state == SPC_ST_RUN && resume_o) else $error("sleep without enable");
    AST_IDLE_CLOCKS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_IDLE
        |-> !cpu_clk_en_o && io_clk_en_o && adc_clk_en_o) else $error("idle clocks wrong");
    AST_ADCNR_CLOCKS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_ADCNR
        |-> !io_clk_en_o && adc_clk_en_o) else $error("adc nr clocks wrong");
    AST_PDOWN_OSC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_PDOWN
        |-> !osc_en_o && input_buf_off_o) else $error("power-down osc running");
    AST_ADC_START: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_sleep_entry ##0 (adc_enabled_i && sel_mode == SPC_MODE_IDLE)
        |=> adc_start_o) else $error("no adc start");
    AST_IRQ_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_IDLE && irq_enabled_i
        && !any_reset_i ##1 !any_reset_i [*4] |=> irq_service_o) else $error("wake timing");
    AST_STBY_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_STBY && irq_pin_change_i
        && !any_reset_i ##1 !any_reset_i [*6] |=> irq_service_o) else $error("standby wake");
    AST_RESET_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state != SPC_ST_RUN && any_reset_i |=> reset_vector_o
        && st_ff.state == SPC_ST_RUN) else $error("reset did not wake");
    AST_PDOWN_NO_IO_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.state == SPC_ST_SLEEP && st_ff.mode == SPC_MODE_PDOWN && !any_reset_i
        && !irq_external_interrupt_zero_level_i && !irq_pin_change_i && !irq_wdt_i
        |=> st_ff.state == SPC_ST_SLEEP) else $error("bad power-down wake");
    AST_GATE_BLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_ff.clk_gate[`SPC_TIM1_BIT] |-> !timer1_clk_en_o
        && (!periph_sel_i[`SPC_TIM1_BIT] || !periph_access_ok_o)) else $error("gate leak");
    AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !avs_waitrequest_o && avs_read_i && avs_address_i == `SPC_CLK_GATE_OFS
        |-> avs_readdata_o[7:4] == 4'h0) else $error("reserved bits set");
endmodule // spc_sleep_ctrl

// >>> testbench/spc_sleep_ctrl_test.sv
// Self-checking bench for the sleep controller: registers, clock gates, sleep entry and wake
// Assumes spc_defs.svh on the include path; drives every port itself, no partner model
`timescale 1ns/1ps
`include "spc_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spc_sleep_ctrl_test;
    logic mclk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, periph_sel_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd, dm, rb;
    logic sleep_instr_i, crystal_clk_i, any_reset_i, irq_enabled_i;
    logic adc_enabled_i, wdt_enabled_i, bod_enabled_i, acmp_bandgap_i;
    logic [5:0] src;
    logic cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, osc_en_o;
    logic timer1_clk_en_o, timer0_clk_en_o, serial_clk_en_o, adcp_clk_en_o;
    logic periph_access_ok_o, adc_start_o, acmp_disable_o, acmp_mux_block_o, input_buf_off_o;
    logic adc_keep_en_o, wdt_keep_en_o, bod_keep_en_o, cpu_halt_o, resume_o;
    logic irq_service_o, reset_vector_o, st, rs, hit, bg;
    logic [3:0] g;
    logic [5:0] good [4];
    logic [5:0] bad [4];
    int wexp [4];
    int num_errors, checks_done, n;

    spc_sleep_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sleep_instr_i(sleep_instr_i), .crystal_clk_i(crystal_clk_i), .any_reset_i(any_reset_i),
        .irq_enabled_i(irq_enabled_i), .irq_adc_done_i(src[5]), .irq_spm_ee_i(src[4]),
        .irq_external_interrupt_zero_level_i(src[3]), .irq_pin_change_i(src[2]), .irq_wdt_i(src[1]),
        .irq_other_io_i(src[0]), .adc_enabled_i(adc_enabled_i), .wdt_enabled_i(wdt_enabled_i),
        .bod_enabled_i(bod_enabled_i), .acmp_bandgap_i(acmp_bandgap_i),
        .periph_sel_i(periph_sel_i), .cpu_clk_en_o(cpu_clk_en_o), .flash_clk_en_o(flash_clk_en_o),
        .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o), .osc_en_o(osc_en_o),
        .timer1_clk_en_o(timer1_clk_en_o), .timer0_clk_en_o(timer0_clk_en_o),
        .serial_clk_en_o(serial_clk_en_o), .adcp_clk_en_o(adcp_clk_en_o),
        .periph_access_ok_o(periph_access_ok_o), .adc_start_o(adc_start_o),
        .acmp_disable_o(acmp_disable_o), .acmp_mux_block_o(acmp_mux_block_o),
        .input_buf_off_o(input_buf_off_o), .adc_keep_en_o(adc_keep_en_o),
        .wdt_keep_en_o(wdt_keep_en_o), .bod_keep_en_o(bod_keep_en_o), .cpu_halt_o(cpu_halt_o),
        .resume_o(resume_o), .irq_service_o(irq_service_o), .reset_vector_o(reset_vector_o));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Samples on the falling edge so that the rising edge's updates have landed
    task tick(input int k);
        repeat (k) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        logic w;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        w = 1'b1;
        q = '0;
        // Waitrequest and read data are taken at the rising edge itself
        for (n = 0; n < 20 && w; n++) begin
            @(posedge mclk_i);
            w = avs_waitrequest_o;
            q = avs_readdata_o;
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (w !== 1'b0) begin
            `CHK(w, 1'b0)
            report_and_stop();
        end
    endtask

    task sleep_pulse(output logic s, output logic r);
        s = 1'b0;
        r = 1'b0;
        @(posedge mclk_i) sleep_instr_i <= 1'b1;
        @(posedge mclk_i) sleep_instr_i <= 1'b0;
        repeat (3) begin
            @(negedge mclk_i);
            s |= adc_start_o;
            r |= resume_o;
            @(posedge mclk_i);
        end
    endtask

    // Clock enables {cpu, flash, io, adc, osc} expected while asleep in each mode
    function automatic logic [4:0] clk_exp(input logic [1:0] m);
        case (m)
            2'b00: return 5'h07;
            2'b01: return 5'h03;
            2'b10: return 5'h00;
            default: return 5'h01;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge mclk_i);
        `CHK(1'b0, 1'b1)
        report_and_stop();
    end

    initial begin
        {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, periph_sel_i} = '0;
        {sleep_instr_i, crystal_clk_i, any_reset_i, irq_enabled_i, src} = '0;
        {adc_enabled_i, wdt_enabled_i, bod_enabled_i, acmp_bandgap_i} = '0;
        num_errors = 0;
        checks_done = 0;
        good = '{6'h01, 6'h20, 6'h08, 6'h04};
        bad = '{6'h00, 6'h01, 6'h20, 6'h20};
        wexp = '{4, 4, 12, 6};
        void'($urandom(32'h9eaf));
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bus(0, `SPC_CORE_CTRL_OFS, 0, rd);
        `CHK(rd, 32'h0)
        bus(0, `SPC_CLK_GATE_OFS, 0, rd);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 4; i++) begin
            rd = (i == 0) ? 32'hffffffff : $urandom;
            bus(1, `SPC_CORE_CTRL_OFS, rd, dm);
            bus(0, `SPC_CORE_CTRL_OFS, 0, rb);
            `CHK(rb, {24'h0, rd[7:0] & `SPC_CORE_CTRL_MASK})
            bus(1, `SPC_CLK_GATE_OFS, rd, dm);
            bus(0, `SPC_CLK_GATE_OFS, 0, rb);
            `CHK(rb, {24'h0, rd[7:0] & `SPC_CLK_GATE_MASK})
        end
        bus(1, 4'hc, 32'hffffffff, rd);
        bus(0, 4'hc, 0, rd);
        `CHK(rd, 32'h0)
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            g = (i == 0) ? 4'hf : 4'($urandom);
            bus(1, `SPC_CLK_GATE_OFS, {28'h0, g}, rd);
            tick(1);
            `CHK({timer1_clk_en_o, timer0_clk_en_o, serial_clk_en_o, adcp_clk_en_o}, ~g)
            `CHK(acmp_mux_block_o, g[0])
            for (int j = 0; j < 4; j++) begin
                @(posedge mclk_i) periph_sel_i <= 4'(1 << j);
                tick(1);
                `CHK(periph_access_ok_o, ~g[j])
            end
        end
        periph_sel_i <= 4'h0;
        bus(1, `SPC_CLK_GATE_OFS, 0, rd);
        tick(1);
        `CHK({timer1_clk_en_o, timer0_clk_en_o, serial_clk_en_o, adcp_clk_en_o}, 4'hf)
        $display("test clock gates done");
        bus(1, `SPC_CORE_CTRL_OFS, 32'h10, rd);
        sleep_pulse(st, rs);
        `CHK(rs, 1'b1)
        `CHK(cpu_clk_en_o, 1'b1)
        $display("test sleep disabled done");
        for (int m = 0; m < 4; m++) begin
            bg = 1'($urandom);
            @(posedge mclk_i);
            adc_enabled_i <= 1'b1;
            crystal_clk_i <= 1'b1;
            acmp_bandgap_i <= bg;
            wdt_enabled_i <= 1'($urandom);
            bod_enabled_i <= 1'($urandom);
            bus(1, `SPC_CORE_CTRL_OFS, 32'h20 | (m << 3), rd);
            sleep_pulse(st, rs);
            `CHK(st, m < 2)
            `CHK({cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, osc_en_o}, clk_exp(2'(m)))
            `CHK(input_buf_off_o, m >= 2)
            `CHK(cpu_halt_o, 1'b1)
            `CHK(acmp_disable_o, (m >= 2) & ~bg)
            `CHK({adc_keep_en_o, wdt_keep_en_o, bod_keep_en_o}, {1'b1, wdt_enabled_i, bod_enabled_i})
            if (m > 0) begin
                @(posedge mclk_i) src <= bad[m];
                hit = 1'b0;
                repeat (20) begin
                    tick(1);
                    hit |= irq_service_o | cpu_clk_en_o;
                end
                `CHK(hit, 1'b0)
                @(posedge mclk_i) src <= 6'h0;
            end
            // The wake level stays up until the wake is seen
            @(posedge mclk_i);
            src <= good[m];
            irq_enabled_i <= 1'b1;
            for (n = 1; n < 40; n++) begin
                tick(1);
                if (irq_service_o === 1'b1) break;
            end
            rs = resume_o;
            `CHK(n >= wexp[m] && n <= wexp[m] + 2, 1'b1)
            `CHK(rs, 1'b1)
            @(posedge mclk_i);
            src <= 6'h0;
            irq_enabled_i <= 1'b0;
            tick(2);
            `CHK(cpu_clk_en_o, 1'b1)
            $display("test sleep mode %0d done", m);
        end
        bus(1, `SPC_CORE_CTRL_OFS, 32'h30, rd);
        sleep_pulse(st, rs);
        @(posedge mclk_i) any_reset_i <= 1'b1;
        @(posedge mclk_i) any_reset_i <= 1'b0;
        hit = 1'b0;
        repeat (5) begin
            tick(0);
            hit |= reset_vector_o;
            @(posedge mclk_i);
        end
        `CHK(hit, 1'b1)
        bus(0, `SPC_CORE_CTRL_OFS, 0, rd);
        `CHK(rd, 32'h0)
        bus(1, `SPC_CLK_GATE_OFS, 32'h0f, rd);
        @(posedge mclk_i) rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bus(0, `SPC_CLK_GATE_OFS, 0, rd);
        `CHK(rd, 32'h0)
        $display("test reset in sleep done");
        report_and_stop();
    end
endmodule // spc_sleep_ctrl_test
